//--- shared/dsa_pkg.sv
// Purpose: Shared constants and types for the differential SAR converter serial readout.
// Assumes: Core clock of 25 MHz; serial clock and select arrive as pins.
// Notes:   Codes are 13-bit two's complement; the search itself runs in offset binary.
package dsa_pkg;

  // Result width and code limits.
  localparam int unsigned        RES_W        = 13;
  localparam logic [RES_W-1:0]   CODE_MOST_NEG = 13'h1000;
  localparam logic [RES_W-1:0]   CODE_MOST_POS = 13'h0fff;
  localparam logic [RES_W-1:0]   CODE_FIRST_POS = 13'h0001;
  localparam logic [RES_W-1:0]   CODE_ZERO     = 13'h0000;
  localparam logic [RES_W-1:0]   SIGN_MASK     = 13'h1000;
  localparam int unsigned        CODE_COUNT    = 8192;

  // Sample window: closed on the first rising edge, open on the second falling edge.
  localparam logic [1:0]         ACQ_FALLS     = 2'h2;
  // Convert window: one serial clock cycle for each result bit.
  localparam logic [3:0]         CONV_BITS     = 4'hd;

  // Core clock and the slowest serial clock worth converting with.
  localparam int unsigned        CLK_HZ        = 25_000_000;
  localparam int unsigned        MIN_SCLK_HZ   = 85_000;
  // Longest gap between falling edges, rounded down to whole core cycles.
  localparam int unsigned        SLOW_GAP_CYC  = CLK_HZ / MIN_SCLK_HZ;
  localparam int unsigned        GAP_W         = 10;
  localparam logic [GAP_W-1:0]   SLOW_GAP_LIM  = GAP_W'(SLOW_GAP_CYC);

  // Reset values of the pin-side outputs.
  localparam logic               DOUT_RST      = 1'b0;
  localparam logic               STANDBY_RST   = 1'b1;

  typedef enum logic [4:0] {
    DSA_STANDBY = 5'h01,
    DSA_WAIT    = 5'h02,
    DSA_ACQ     = 5'h04,
    DSA_CONV    = 5'h08,
    DSA_DONE    = 5'h10
  } dsa_state_t;

  // Offset binary and two's complement differ only in the top bit.
  function automatic logic [RES_W-1:0] dsa_flip_sign(input logic [RES_W-1:0] code);
    dsa_flip_sign = code ^ SIGN_MASK;
  endfunction : dsa_flip_sign

endpackage : dsa_pkg

//--- src/dsa_sar.sv
// Purpose: Successive-approximation register, one decision per step.
// Assumes: Comparator input is high when the held difference is at or above the trial level.
// Notes:   Searches in offset binary and hands out two's complement to the outside.
`timescale 1ns/1ps
`default_nettype none

module dsa_sar #(
  parameter int unsigned W = dsa_pkg::RES_W
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clear,
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         cmp_ge,
  output logic [W-1:0]      trial,
  output logic              decide_bit,
  output logic              final_step,
  output logic [W-1:0]      result_next
);

  logic [W-1:0] code_q;
  logic [W-1:0] mask_q;
  logic [W-1:0] kept;

  // A failed trial drops the bit under test; a passed one keeps it.
  assign kept        = cmp_ge ? code_q : (code_q & ~mask_q);
  assign trial       = dsa_pkg::dsa_flip_sign(code_q);
  assign final_step  = mask_q[0];
  assign result_next = dsa_pkg::dsa_flip_sign(kept);
  // The top bit goes out as a sign: zero when the positive input is higher.
  assign decide_bit  = mask_q[W-1] ? ~cmp_ge : cmp_ge;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_q <= '0;
      mask_q <= '0;
    end
    else if (clear)
    begin
      code_q <= '0;
      mask_q <= '0;
    end
    else if (start)
    begin
      code_q <= dsa_pkg::SIGN_MASK;
      mask_q <= dsa_pkg::SIGN_MASK;
    end
    else if (step && (mask_q != '0))
    begin
      code_q <= kept | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end

endmodule : dsa_sar

`default_nettype wire

//--- src/dsa_readout.sv
// Purpose: Digital side of a 13-bit differential SAR converter with a read-only serial port.
// Assumes: Host drives serial clock and active-low select; core clock is much faster than both.
// Notes:   Serial clock and select are pins, so both are resynchronised here; only the serial clock is edge-detected.
//
// How it works
// [RULE1] Select going low starts a transaction.
// [RULE2] Select going high aborts any conversion and enters standby.
// [RULE3] Host must raise select between conversions.
// [RULE4] Serial output changes only on serial clock falling edges, one bit each.
// [RULE5] Serial clock starts conversion; each bit leaves as soon as resolved.
// [RULE6] Sample switches stay closed for 1.5 serial clock cycles.
// [RULE7] Both inputs sampled together; hold switches open after acquisition.
// [RULE8] Host supplies 13 more serial clocks, one per result bit.
// [RULE9] Result is 13-bit two's complement, most significant bit first.
// [RULE10] First bit is the sign showing which input is higher.
// [RULE11] Host should keep serial clock at or above 85 kHz while converting.
// [RULE12] No other rate or duty cycle demand on the host.
// [RULE13] 8192 codes over the bipolar range; one polarity gives 12 bits.
// [RULE14] Most negative 0x1000, most positive 0x0fff, first above zero 0x0001.
// [RULE15] Sign is zero when positive input is higher, one otherwise.
// [RULE16] Largest positive result is +4095.
// [RULE17] Serial output driven only while select is low, else released.
// [RULE18] After the last bit, no new sample until select toggles.
`timescale 1ns/1ps
`default_nettype none

module dsa_readout #(
  parameter int unsigned W = dsa_pkg::RES_W
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         sclk,
  input  wire logic         select_shutdown_n,
  input  wire logic         cmp_ge,
  output logic              dout_o,
  output logic              dout_oe,
  output logic              sample_closed,
  output logic [W-1:0]      dac_trial,
  output logic              standby,
  output logic [W-1:0]      result,
  output logic              result_valid,
  output logic              slow_clock
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic       sclk_s1_q;
  logic       sclk_s2_q;
  logic       sclk_s3_q;
  logic       sel_s1_q;
  logic       sel_s2_q;
  logic       cmp_s1_q;
  logic       cmp_s2_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sel_s1_q  <= 1'b1;
      sel_s2_q  <= 1'b1;
      cmp_s1_q  <= 1'b0;
      cmp_s2_q  <= 1'b0;
    end
    else
    begin
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sel_s1_q  <= select_shutdown_n;
      sel_s2_q  <= sel_s1_q;
      cmp_s1_q  <= cmp_ge;
      cmp_s2_q  <= cmp_s1_q;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic selected;

  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
  assign selected  = ~sel_s2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer.

  dsa_pkg::dsa_state_t state_q;
  dsa_pkg::dsa_state_t state_d;
  logic [1:0]          fall_cnt_q;
  logic [3:0]          bit_cnt_q;

  logic                sar_clear;
  logic                sar_start;
  logic                sar_step;
  logic [W-1:0]        sar_trial;
  logic                sar_bit;
  logic                sar_final;
  logic [W-1:0]        sar_result;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dsa_pkg::DSA_STANDBY:
      begin
        if (selected)
          state_d = dsa_pkg::DSA_WAIT;                             // [RULE1]
      end
      dsa_pkg::DSA_WAIT:
      begin
        if (sclk_rise)
          state_d = dsa_pkg::DSA_ACQ;                              // [RULE5]
      end
      dsa_pkg::DSA_ACQ:
      begin
        if (sclk_fall && (fall_cnt_q == dsa_pkg::ACQ_FALLS - 2'h1))
          state_d = dsa_pkg::DSA_CONV;                             // [RULE6]
      end
      dsa_pkg::DSA_CONV:
      begin
        if (sclk_fall && (bit_cnt_q == dsa_pkg::CONV_BITS - 4'h1))
          state_d = dsa_pkg::DSA_DONE;                             // [RULE8]
      end
      dsa_pkg::DSA_DONE:
      begin
        state_d = dsa_pkg::DSA_DONE;                               // [RULE18]
      end
      default:
      begin
        state_d = dsa_pkg::DSA_STANDBY;
      end
    endcase
    // Deselect wins from every state, so an abort never leaves a half search behind.
    if (!selected)
      state_d = dsa_pkg::DSA_STANDBY;                              // [RULE2]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= dsa_pkg::DSA_STANDBY;
    else
      state_q <= state_d;
  end

  // Falling edges seen during acquisition.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fall_cnt_q <= 2'h0;
    else if (state_q != dsa_pkg::DSA_ACQ)
      fall_cnt_q <= 2'h0;
    else if (sclk_fall)
      fall_cnt_q <= fall_cnt_q + 2'h1;
  end

  // Bits sent so far in this conversion.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bit_cnt_q <= 4'h0;
    else if (state_q != dsa_pkg::DSA_CONV)
      bit_cnt_q <= 4'h0;
    else if (sclk_fall)
      bit_cnt_q <= bit_cnt_q + 4'h1;
  end

  assign sar_clear = !selected;
  assign sar_start = (state_q == dsa_pkg::DSA_ACQ) && (state_d == dsa_pkg::DSA_CONV);
  assign sar_step  = (state_q == dsa_pkg::DSA_CONV) && sclk_fall && selected;

  dsa_sar #(
    .W (W)
  ) u_sar (
    .clk         (clk),
    .nrst        (nrst),
    .clear       (sar_clear),
    .start       (sar_start),
    .step        (sar_step),
    .cmp_ge      (cmp_s2_q),
    .trial       (sar_trial),
    .decide_bit  (sar_bit),
    .final_step  (sar_final),
    .result_next (sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Analog switch control and DAC trial level.

  // One control for both inputs keeps the two sampling instants identical.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sample_closed <= 1'b0;
    else
      sample_closed <= (state_d == dsa_pkg::DSA_ACQ);              // [RULE6] [RULE7]
  end

  // Conversion works only on held charge; the trial level is all that moves.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dac_trial <= dsa_pkg::CODE_ZERO;
    else
      dac_trial <= sar_trial;                                      // [RULE7]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      standby <= dsa_pkg::STANDBY_RST;
    else
      standby <= (state_d == dsa_pkg::DSA_STANDBY);                // [RULE2]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output.

  // The sign is decided first, so the word leaves MSB first in two's complement.
  // The last bit stands until deselect, so a host that samples late still catches it.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dout_o <= dsa_pkg::DOUT_RST;
    else if (!selected)
      dout_o <= dsa_pkg::DOUT_RST;
    else if (sar_step)
      dout_o <= sar_bit;                         // [RULE4] [RULE5] [RULE9] [RULE10] [RULE15]
  end

  // Released while deselected so several converters can share the data line.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dout_oe <= 1'b0;
    else
      dout_oe <= selected;                                         // [RULE17]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parallel copy of the finished word.

  // Search covers offset 0..8191, i.e. two's complement 0x1000 up to 0x0fff.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      result <= dsa_pkg::CODE_ZERO;
    else if (sar_step && sar_final)
      result <= sar_result;                                  // [RULE13] [RULE14] [RULE16]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      result_valid <= 1'b0;
    else
      result_valid <= sar_step && sar_final;                       // [RULE9]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slow serial clock watch.

  // The host may clock as slowly as it likes; held charge decays meanwhile,
  // so a gap longer than the 85 kHz period is only flagged, never refused.
  logic [dsa_pkg::GAP_W-1:0] gap_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gap_q <= '0;
    else if ((state_q != dsa_pkg::DSA_CONV) || sclk_fall)
      gap_q <= '0;
    else if (gap_q != dsa_pkg::SLOW_GAP_LIM)
      gap_q <= gap_q + dsa_pkg::GAP_W'(1);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      slow_clock <= 1'b0;
    else if ((state_q == dsa_pkg::DSA_ACQ) && (state_d == dsa_pkg::DSA_CONV))
      slow_clock <= 1'b0;
    else if ((state_q == dsa_pkg::DSA_CONV) && (gap_q == dsa_pkg::SLOW_GAP_LIM))
      slow_clock <= 1'b1;                                          // [RULE11] [RULE12]
  end

endmodule : dsa_readout

`default_nettype wire

//--- verif/dsa_readout_monitor.sv
// Purpose: Port-level checker for the serial readout.
// Assumes: Select stays high while nrst is low.
// Notes:   Latency windows allow for the pin resync stages.
`timescale 1ns/1ps
`default_nettype none
module dsa_readout_monitor #(
  parameter int unsigned W = dsa_pkg::RES_W
) (
  input wire logic         clk,
  input wire logic         nrst,
  input wire logic         sclk,
  input wire logic         select_shutdown_n,
  input wire logic         cmp_ge,
  input wire logic         dout_o,
  input wire logic         dout_oe,
  input wire logic         sample_closed,
  input wire logic [W-1:0] dac_trial,
  input wire logic         standby,
  input wire logic [W-1:0] result,
  input wire logic         result_valid,
  input wire logic         slow_clock
);
  localparam int SLOW_MIN = 290;
  logic       sclk_q;
  logic [9:0] since_fall;
  logic [1:0] acq_falls;
  logic       done_q;
  wire logic  sfall = sclk_q & ~sclk;
  ////////////////
  // The counter saturates so a stalled host cannot wrap it into a false pass.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q     <= 1'b0;
      since_fall <= 10'h3ff;
    end
    else
    begin
      sclk_q     <= sclk;
      since_fall <= sfall ? 10'h000 : since_fall + {9'h000, ~&since_fall};
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acq_falls <= 2'h0;
      done_q    <= 1'b0;
    end
    else
    begin
      acq_falls <= !sample_closed ? 2'h0 : acq_falls + {1'b0, sfall};
      done_q    <= standby ? 1'b0 : (done_q | result_valid);
    end
  end
  ////////////////
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_oe_on_select: assert property ($fell(select_shutdown_n) |-> ##[2:4] dout_oe)
    else $error("output not enabled after select fell");
  a_standby_on_rise: assert property ($rose(select_shutdown_n) |-> ##[2:4] standby)
    else $error("no standby after select rose");
  a_standby_quiet: assert property (standby |-> !dout_oe && !dout_o && !sample_closed)
    else $error("activity during standby");
  a_oe_needs_sel: assert property (dout_oe |-> !$past(select_shutdown_n, 3))
    else $error("output driven while deselected");
  a_dout_on_fall: assert property ($changed(dout_o) && dout_oe && $past(dout_oe) |->
    since_fall <= 6)
    else $error("serial output changed away from a falling edge");
  a_close_on_rise: assert property ($rose(sample_closed) |-> sclk && dout_oe)
    else $error("sampling closed without a serial clock rise");
  a_acq_span: assert property ($fell(sample_closed) |-> acq_falls == 2'h2)
    else $error("acquisition not ended by the second fall");
  a_word_pulse: assert property (result_valid |->
    (dout_oe && dout_o == result[0] && since_fall <= 6) ##1 !result_valid)
    else $error("result pulse not aligned with the last bit");
  a_done_quiet: assert property (done_q |-> !sample_closed && !result_valid)
    else $error("new sample before select toggled");
  a_slow_gap: assert property ($rose(slow_clock) |-> since_fall >= SLOW_MIN)
    else $error("slow flag without a long gap");
  c_word: cover property (result_valid);
  c_abort: cover property ($rose(select_shutdown_n) && !done_q && !standby);
  c_slow: cover property ($rose(slow_clock));
endmodule : dsa_readout_monitor
bind dsa_readout dsa_readout_monitor #(.W(W)) mon_u (
  .clk(clk), .nrst(nrst), .sclk(sclk), .select_shutdown_n(select_shutdown_n),
  .cmp_ge(cmp_ge), .dout_o(dout_o), .dout_oe(dout_oe), .sample_closed(sample_closed),
  .dac_trial(dac_trial), .standby(standby), .result(result),
  .result_valid(result_valid), .slow_clock(slow_clock)
);
`default_nettype wire

//--- verif/dsa_host.sv
// Purpose: Host side of the serial port: select, serial clock, bit capture.
// Assumes: Serial clock idles low and stands still outside frames.
// Notes:   One clock phase lasts half core cycles.
`timescale 1ns/1ps
`default_nettype none
module dsa_host (
  input  wire logic clk,
  input  wire logic dout_o,
  input  wire logic dout_oe,
  output logic      sclk,
  output logic      select_shutdown_n
);
  initial
  begin
    sclk              = 1'b0;
    select_shutdown_n = 1'b1;
  end
  // Falls 0 and 1 end acquisition; falls 2 to 14 carry the word.
  task automatic run(input int falls, input int half, output logic [12:0] w);
    int i;
    w = 13'h0000;
    @(posedge clk);
    select_shutdown_n <= 1'b0;
    repeat (10) @(posedge clk);
    for (i = 0; i < falls; i++)
    begin
      sclk <= 1'b1;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
      repeat (half) @(posedge clk);
      if (i >= 2 && i < 15)
        w = {w[11:0], dout_oe ? dout_o : ~dout_o};
    end
    select_shutdown_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : run
endmodule : dsa_host
`default_nettype wire

//--- verif/tb.sv
// Purpose: Self-checking bench for the serial readout.
// Assumes: Ideal comparator; the difference is given in code steps.
// Notes:   Aborts, extra clocks and a slow clock come from the host model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk;
  logic        nrst;
  logic        cmp_ge;
  logic [12:0] diff;
  logic        sclk;
  logic        select_shutdown_n;
  logic        dout_o;
  logic        dout_oe;
  logic        sample_closed;
  logic        standby;
  logic        result_valid;
  logic        slow_clock;
  logic [12:0] dac_trial;
  logic [12:0] result;
  int          bad_count;
  int          checked;
  dsa_readout dut_u (
    .clk(clk), .nrst(nrst), .sclk(sclk), .select_shutdown_n(select_shutdown_n),
    .cmp_ge(cmp_ge), .dout_o(dout_o), .dout_oe(dout_oe), .sample_closed(sample_closed),
    .dac_trial(dac_trial), .standby(standby), .result(result),
    .result_valid(result_valid), .slow_clock(slow_clock)
  );
  dsa_host host_u (
    .clk(clk), .dout_o(dout_o), .dout_oe(dout_oe), .sclk(sclk),
    .select_shutdown_n(select_shutdown_n)
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
    cmp_ge <= $signed(diff) >= $signed(dac_trial);
  ////////////////
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conv(input logic [12:0] d, input int falls, input int half);
    logic [12:0] w;
    @(posedge clk);
    diff <= d;
    host_u.run(falls, half, w);
    chk(w, d);
    chk(result, d);
  endtask : conv
  task automatic t_codes;
    logic [12:0] tbl [7] = '{13'h0000, 13'h0001, 13'h1fff, 13'h0fff, 13'h1000,
                              13'h0aaa, 13'h1555};
    foreach (tbl[k])
      conv(tbl[k], 15, 8);
  endtask : t_codes
  task automatic t_abort;
    logic [12:0] w;
    @(posedge clk);
    diff <= 13'h0abc;
    host_u.run(6, 8, w);
    chk(result, 13'h1555);
    chk({11'h000, dout_oe, standby}, 13'h0001);
  endtask : t_abort
  // Clocks beyond the word must not start a second sample.
  task automatic t_late;
    conv(13'h0777, 18, 8);
    conv(13'h1888, 15, 8);
  endtask : t_late
  task automatic t_slow;
    conv(13'h0321, 15, 200);
    chk({12'h000, slow_clock}, 13'h0001);
    conv(13'h1234, 15, 8);
    chk({12'h000, slow_clock}, 13'h0000);
  endtask : t_slow
  task automatic tally_and_finish;
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  ////////////////
  initial
  begin
    nrst      = 1'b0;
    diff      = 13'h0000;
    bad_count = 0;
    checked   = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({9'h000, dout_oe, standby, result_valid, slow_clock}, 13'h0004);
    chk(result, 13'h0000);
    t_codes;
    t_abort;
    t_late;
    t_slow;
    tally_and_finish;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
